// *** rtl/phy_ext_pkg.sv ***
// Purpose: shared constants and carriers for the extended management register bank
// Assumes: 16-bit management data, 5-bit register address field
// Notes:   register words are packed structs so field positions live in one place
package phy_ext_pkg;

    localparam int DATA_W = 16;

    // register address field values
    localparam logic [4:0] REG_LBR       = 5'h11;
    localparam logic [4:0] REG_RXCNT     = 5'h12;
    localparam logic [4:0] REG_TEN       = 5'h13;
    localparam logic [4:0] REG_PAR_A     = 5'h14;
    localparam logic [4:0] REG_PAR_B     = 5'h15;
    localparam logic [4:0] REG_CABLE_PLL = 5'h16;
    localparam logic [4:0] REG_TP_A      = 5'h17;

    // writable bits and values after reset
    localparam logic [15:0] LBR_WMASK  = 16'hFB9F;
    localparam logic [15:0] LBR_RESET  = 16'h0080;
    localparam logic [15:0] TEN_WMASK  = 16'h0023;
    localparam logic [15:0] TEN_RESET  = 16'h0023;
    localparam logic [15:0] PAR_RESET  = 16'h0000;
    localparam logic [7:0]  PLL_RESET  = 8'h00;
    localparam logic [15:0] CNT_RESET  = 16'h0000;

    // management frame
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [3:0] OP_LAST       = 4'h1;
    localparam logic [3:0] ADDR_LAST     = 4'h9;
    localparam logic [3:0] DATA_LAST     = 4'hF;
    localparam logic [1:0] STRAP_TAKE    = 2'h2;
    localparam logic [1:0] STRAP_DONE    = 2'h3;

    typedef enum logic [1:0] {
        LOOP_NORMAL  = 2'b00,
        LOOP_PHY     = 2'b01,
        LOOP_TWISTED = 2'b10
    } loop_mode_t;

    typedef enum logic [2:0] {
        ST_PREAMBLE = 3'b000,
        ST_START    = 3'b001,
        ST_OP       = 3'b010,
        ST_ADDR     = 3'b011,
        ST_TA       = 3'b100,
        ST_DATA     = 3'b101
    } frame_state_t;

    typedef struct packed {
        logic       repeater_mode_sel;
        logic       block_code_bypass;
        logic       scrambler_bypass;
        logic       link_down_power_save;
        logic       analog_power_down;
        logic       length_detect_ok_n;
        logic [1:0] loopback_select;
        logic       force_link_100;
        logic [1:0] reserved_6_5;
        logic       code_error_report;
        logic       early_end_error_report;
        logic       link_error_report;
        logic       packet_timeout_error_report;
        logic       parameter_access_enable;
    } lbr_word_t;

    typedef struct packed {
        logic [9:0] reserved_15_6;
        logic       twisted_pair_link_disable_n;
        logic [2:0] reserved_4_2;
        logic       heartbeat_enable;
        logic       jabber_enable;
    } ten_word_t;

    typedef struct packed {
        logic code_error;
        logic early_end;
        logic link_error;
        logic packet_timeout;
        logic valid_packet;
    } rx_events_t;

endpackage

// *** rtl/sync2.sv ***
// Purpose: two flip-flop synchroniser, also used to release the reset
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second stage
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule // sync2

// *** rtl/rx_event_counter.sv ***
// Purpose: loadable counter for received events
// Assumes: load and incr come from the same clock
// Notes:   a load wins over a same-cycle increment; wraps at all ones
module rx_event_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             incr,
    output logic      [WIDTH-1:0] count
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (incr) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule // rx_event_counter

// *** rtl/phy_extended_config_regs.sv ***
// Purpose: extended management registers 17..23 behind the serial management pins
// Assumes: mdc at most one quarter of the clock rate; straps stable at reset
// Notes:   every frame needs its full preamble; other addresses read zero
module phy_extended_config_regs (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    mdc,
    input  wire logic                    mdio_in,
    output logic                         mdio_out,
    output logic                         mdio_oe,
    input  wire logic [4:0]              phy_address,
    input  wire logic                    length_detect_ok_n,
    input  wire logic [7:0]              cable_length_result,
    input  wire phy_ext_pkg::rx_events_t rx_events,
    output phy_ext_pkg::lbr_word_t       lbr_ctrl,
    output phy_ext_pkg::ten_word_t       ten_ctrl,
    output logic                         phy_loopback,
    output logic                         twisted_pair_loopback,
    output logic                         rx_error_report,
    output logic [15:0]                  receive_event_count,
    output logic [15:0]                  parameter_word_one_a,
    output logic [15:0]                  parameter_word_one_b,
    output logic [15:0]                  twisted_pair_param_a,
    output logic [7:0]                   pll_select
);
    logic                      rst_n;
    logic [6:0]                pins_s;
    logic                      mdc_s;
    logic                      mdio_s;
    logic [4:0]                addr_s;
    logic                      mdc_prev;
    logic [1:0]                strap_wait;
    logic [4:0]                own_address;
    phy_ext_pkg::frame_state_t state;
    phy_ext_pkg::frame_state_t next_state;
    logic [5:0]                ones;
    logic [5:0]                next_ones;
    logic [3:0]                bit_cnt;
    logic [3:0]                next_cnt;
    logic [1:0]                op;
    logic [1:0]                next_op;
    logic [9:0]                addr_sh;
    logic [9:0]                next_addr;
    logic [15:0]               data_sh;
    logic [15:0]               next_data;
    logic                      next_out;
    logic                      next_oe;
    logic                      next_wr;
    logic                      wr_en;
    phy_ext_pkg::lbr_word_t    lbr_reg;
    phy_ext_pkg::lbr_word_t    lbr_read;
    phy_ext_pkg::ten_word_t    ten_reg;
    logic [15:0]               read_word;

    sync2 #(.WIDTH(1)) u_rst_sync (
        .clock (clock),
        .rst_n (nrst),
        .d     (1'h1),
        .q     (rst_n)
    );

    sync2 #(.WIDTH(7)) u_pin_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({mdc, mdio_in, phy_address}),
        .q     (pins_s)
    );

    assign mdc_s  = pins_s[6];
    assign mdio_s = pins_s[5];
    assign addr_s = pins_s[4:0];

    // strap is taken once the synchroniser holds post-reset pin levels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_wait  <= 2'h0;
            own_address <= 5'h00;
            mdc_prev    <= 1'h0;
        end else begin
            mdc_prev <= mdc_s;
            if (strap_wait != phy_ext_pkg::STRAP_DONE) begin
                strap_wait <= strap_wait + 2'h1;
            end
            if (strap_wait == phy_ext_pkg::STRAP_TAKE) begin
                own_address <= addr_s;
            end
        end
    end

    wire       frame_tick = mdc_s & ~mdc_prev & (strap_wait == phy_ext_pkg::STRAP_DONE);
    wire [4:0] reg_sel    = addr_sh[4:0];
    wire       addr_hit   = addr_sh[9:5] == own_address;
    wire       read_hit   = addr_hit && (op == phy_ext_pkg::OP_READ);
    wire       write_hit  = addr_hit && (op == phy_ext_pkg::OP_WRITE);

    always_comb begin
        next_state = state;
        next_ones  = ones;
        next_cnt   = bit_cnt;
        next_op    = op;
        next_addr  = addr_sh;
        next_data  = data_sh;
        next_out   = mdio_out;
        next_oe    = mdio_oe;
        next_wr    = 1'h0;
        if (frame_tick) begin
            unique case (state)
                phy_ext_pkg::ST_PREAMBLE: begin
                    if (mdio_s) begin
                        if (ones != phy_ext_pkg::PREAMBLE_ONES) begin
                            next_ones = ones + 6'h01;
                        end
                    end else begin
                        next_ones = 6'h00;
                        if (ones == phy_ext_pkg::PREAMBLE_ONES) begin
                            next_state = phy_ext_pkg::ST_START;
                        end
                    end
                end
                phy_ext_pkg::ST_START: begin
                    next_cnt   = 4'h0;
                    next_state = mdio_s ? phy_ext_pkg::ST_OP : phy_ext_pkg::ST_PREAMBLE;
                end
                phy_ext_pkg::ST_OP: begin
                    next_op  = {op[0], mdio_s};
                    next_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == phy_ext_pkg::OP_LAST) begin
                        next_cnt   = 4'h0;
                        next_state = phy_ext_pkg::ST_ADDR;
                    end
                end
                phy_ext_pkg::ST_ADDR: begin
                    next_addr = {addr_sh[8:0], mdio_s};
                    next_cnt  = bit_cnt + 4'h1;
                    if (bit_cnt == phy_ext_pkg::ADDR_LAST) begin
                        next_cnt   = 4'h0;
                        next_state = phy_ext_pkg::ST_TA;
                    end
                end
                phy_ext_pkg::ST_TA: begin
                    if (bit_cnt == 4'h0) begin
                        // pin stays released in the first turnaround bit
                        next_cnt = 4'h1;
                        if (read_hit) begin
                            next_oe   = 1'h1;
                            next_out  = 1'h0;
                            next_data = read_word;
                        end
                    end else begin
                        next_cnt   = 4'h0;
                        next_state = phy_ext_pkg::ST_DATA;
                        if (read_hit) begin
                            next_out  = data_sh[15];
                            next_data = {data_sh[14:0], 1'h0};
                        end
                    end
                end
                phy_ext_pkg::ST_DATA: begin
                    next_cnt = bit_cnt + 4'h1;
                    if (!read_hit) begin
                        next_data = {data_sh[14:0], mdio_s};
                    end
                    if (bit_cnt == phy_ext_pkg::DATA_LAST) begin
                        next_cnt   = 4'h0;
                        next_state = phy_ext_pkg::ST_PREAMBLE;
                        next_oe    = 1'h0;
                        next_out   = 1'h0;
                        next_wr    = write_hit;
                    end else if (read_hit) begin
                        next_out  = data_sh[15];
                        next_data = {data_sh[14:0], 1'h0};
                    end
                end
                default: begin
                    next_state = phy_ext_pkg::ST_PREAMBLE;
                    next_oe    = 1'h0;
                    next_out   = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= phy_ext_pkg::ST_PREAMBLE;
            ones     <= 6'h00;
            bit_cnt  <= 4'h0;
            op       <= 2'h0;
            addr_sh  <= 10'h000;
            data_sh  <= 16'h0000;
            mdio_out <= 1'h0;
            mdio_oe  <= 1'h0;
            wr_en    <= 1'h0;
        end else begin
            state    <= next_state;
            ones     <= next_ones;
            bit_cnt  <= next_cnt;
            op       <= next_op;
            addr_sh  <= next_addr;
            data_sh  <= next_data;
            mdio_out <= next_out;
            mdio_oe  <= next_oe;
            wr_en    <= next_wr;
        end
    end

    // parameter registers gated by access enable
    wire param_ok   = lbr_reg.parameter_access_enable;
    wire wr_lbr     = wr_en && (reg_sel == phy_ext_pkg::REG_LBR);
    wire wr_cnt     = wr_en && (reg_sel == phy_ext_pkg::REG_RXCNT);
    wire wr_ten     = wr_en && (reg_sel == phy_ext_pkg::REG_TEN);
    wire wr_par_a   = wr_en && param_ok && (reg_sel == phy_ext_pkg::REG_PAR_A);
    wire wr_par_b   = wr_en && param_ok && (reg_sel == phy_ext_pkg::REG_PAR_B);
    wire wr_pll     = wr_en && param_ok && (reg_sel == phy_ext_pkg::REG_CABLE_PLL);
    wire wr_tp_a    = wr_en && param_ok && (reg_sel == phy_ext_pkg::REG_TP_A);

    // reserved and read-only bits never stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lbr_reg <= phy_ext_pkg::LBR_RESET;
            ten_reg <= phy_ext_pkg::TEN_RESET;
        end else begin
            if (wr_lbr) begin
                lbr_reg <= data_sh & phy_ext_pkg::LBR_WMASK;
            end
            if (wr_ten) begin
                ten_reg <= data_sh & phy_ext_pkg::TEN_WMASK;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parameter_word_one_a <= phy_ext_pkg::PAR_RESET;
            parameter_word_one_b <= phy_ext_pkg::PAR_RESET;
            twisted_pair_param_a <= phy_ext_pkg::PAR_RESET;
            pll_select           <= phy_ext_pkg::PLL_RESET;
        end else begin
            if (wr_par_a) parameter_word_one_a <= data_sh;
            if (wr_par_b) parameter_word_one_b <= data_sh;
            if (wr_tp_a) twisted_pair_param_a <= data_sh;
            if (wr_pll) pll_select <= data_sh[7:0];
        end
    end

    // valid packet counter, a management write wins
    rx_event_counter #(.WIDTH(phy_ext_pkg::DATA_W)) u_counter (
        .clock      (clock),
        .rst_n      (rst_n),
        .load       (wr_cnt),
        .load_value (data_sh),
        .incr       (rx_events.valid_packet),
        .count      (receive_event_count)
    );

    wire [3:0] err_seen = {rx_events.code_error, rx_events.early_end,
                           rx_events.link_error, rx_events.packet_timeout};
    wire [3:0] err_mask = lbr_reg[4:1];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_error_report <= 1'h0;
        end else begin
            rx_error_report <= |(err_seen & err_mask);
        end
    end

    always_comb begin
        lbr_read                    = lbr_reg;
        lbr_read.length_detect_ok_n = length_detect_ok_n;
    end

    // read selection; gated words read zero
    wire [15:0] param_word =
        (reg_sel == phy_ext_pkg::REG_PAR_A)     ? parameter_word_one_a :
        (reg_sel == phy_ext_pkg::REG_PAR_B)     ? parameter_word_one_b :
        (reg_sel == phy_ext_pkg::REG_CABLE_PLL) ? {cable_length_result, pll_select} :
        (reg_sel == phy_ext_pkg::REG_TP_A)      ? twisted_pair_param_a : 16'h0000;

    assign read_word =
        (reg_sel == phy_ext_pkg::REG_LBR)   ? lbr_read :
        (reg_sel == phy_ext_pkg::REG_RXCNT) ? receive_event_count :
        (reg_sel == phy_ext_pkg::REG_TEN)   ? ten_reg :
        param_ok                            ? param_word : 16'h0000;

    assign lbr_ctrl = lbr_read;
    assign ten_ctrl = ten_reg;

    // loopback decode; code 11 selects neither
    assign phy_loopback          = lbr_reg.loopback_select == phy_ext_pkg::LOOP_PHY;
    assign twisted_pair_loopback = lbr_reg.loopback_select == phy_ext_pkg::LOOP_TWISTED;

    lbr_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_lbr |=> lbr_reg == ($past(data_sh) & phy_ext_pkg::LBR_WMASK))
        else $error("control register write not stored");

    len_status_a: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_sel == phy_ext_pkg::REG_LBR) |-> read_word[10] == length_detect_ok_n)
        else $error("length detect status not reflected");

    count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rx_events.valid_packet && !wr_cnt)
        |=> receive_event_count == $past(receive_event_count) + 16'h0001)
        else $error("packet counter did not step");

    gate_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!param_ok && reg_sel >= phy_ext_pkg::REG_PAR_A && reg_sel <= phy_ext_pkg::REG_TP_A)
        |-> read_word == 16'h0000)
        else $error("gated parameter word readable");

    gate_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_en && !param_ok && reg_sel == phy_ext_pkg::REG_PAR_A)
        |=> $stable(parameter_word_one_a))
        else $error("gated parameter word written");

    reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        (ten_reg & ~phy_ext_pkg::TEN_WMASK) == 16'h0000)
        else $error("reserved bit set in register 19");

    err_report_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rx_events.code_error && lbr_reg.code_error_report) |=> rx_error_report)
        else $error("code error not reported");

    cable_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
        (param_ok && reg_sel == phy_ext_pkg::REG_CABLE_PLL)
        |-> read_word[15:8] == cable_length_result)
        else $error("cable length byte wrong");

    ta_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(mdio_oe) |-> (!mdio_out && state == phy_ext_pkg::ST_TA && read_hit))
        else $error("turnaround drive wrong");

    idle_release_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state == phy_ext_pkg::ST_PREAMBLE) |-> !mdio_oe)
        else $error("pin driven outside read data");
endmodule // phy_extended_config_regs

// *** bench/mgmt_station.sv ***
// Purpose: station management model driving the serial management pins
// Assumes: mdc halves of 8 system clocks, well above the 4-clock minimum
// Notes:   mdc stands low and mdio is released between frames
module mgmt_station (
    input  wire logic clock,
    input  wire logic mdio_line,
    output logic      mdc,
    output logic      mdio_drv,
    output logic      mdio_drv_en
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        mdc = 1'b0;
        mdio_drv = 1'b1;
        mdio_drv_en = 1'b0;
    end

    // data changes while mdc is low, line is sampled at the rise
    task automatic bit_cycle(input logic val, input logic en, output logic seen);
        mdio_drv = val;
        mdio_drv_en = en;
        repeat (8) @(posedge clock);
        #1 mdc = 1'b1;
        seen = mdio_line;
        repeat (8) @(posedge clock);
        #1 mdc = 1'b0;
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phyad,
                         input logic [4:0] register_address_field, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic        seen;
        logic [13:0] head;
        logic [17:0] tail;
        head = {2'b01, op, phyad, register_address_field};
        tail = {2'b10, wdata};
        // full preamble, then start, opcode, 5-bit PHY address and 5-bit register address
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, seen);
        for (int i = 13; i >= 0; i--) bit_cycle(head[i], 1'b1, seen);
        // a read leaves turnaround and data to the device
        for (int i = 17; i >= 0; i--) begin
            bit_cycle(tail[i], op == 2'b01, seen);
            rdata = {rdata[14:0], seen};
        end
        mdio_drv_en = 1'b0;
        // return off the edge so callers never change inputs on a sampling edge
        repeat (6) @(posedge clock);
        #1;
    endtask
endmodule // mgmt_station

// *** bench/tb_phy_extended_config_regs.sv ***
// Purpose: self-checking bench for the extended management registers
// Assumes: strap address fixed, status inputs driven by the bench
// Notes:   every register access goes through full management frames
module tb_phy_extended_config_regs;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [4:0] PHYAD = 5'h05;
    logic                    clock;
    logic                    nrst;
    logic                    mdc;
    logic                    sta_d;
    logic                    sta_en;
    logic                    mdio_out;
    logic                    mdio_oe;
    logic                    length_detect_ok_n;
    phy_ext_pkg::rx_events_t rx_events;
    phy_ext_pkg::lbr_word_t  lbr_ctrl;
    phy_ext_pkg::ten_word_t  ten_ctrl;
    logic                    phy_loopback;
    logic                    twisted_pair_loopback;
    logic                    rx_error_report;
    logic [15:0]             receive_event_count;
    logic [15:0]             par_a;
    logic [15:0]             par_b;
    logic [15:0]             tp_a;
    logic [7:0]              pll_select;
    logic [7:0]              cable_len;
    logic [15:0]             rd;
    logic [15:0]             vals [4] = '{16'h1234, 16'hBEEF, 16'h5A3C, 16'hC0DE};
    int                      errors;
    int                      num_checks;
    // pull-up holds the line high when nobody drives it
    wire                     mdio_line = sta_en ? sta_d : (mdio_oe ? mdio_out : 1'b1);

    phy_extended_config_regs dut (.clock(clock), .nrst(nrst), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_address(PHYAD), .length_detect_ok_n(length_detect_ok_n),
        .cable_length_result(cable_len), .rx_events(rx_events), .lbr_ctrl(lbr_ctrl),
        .ten_ctrl(ten_ctrl), .phy_loopback(phy_loopback),
        .twisted_pair_loopback(twisted_pair_loopback), .rx_error_report(rx_error_report),
        .receive_event_count(receive_event_count), .parameter_word_one_a(par_a),
        .parameter_word_one_b(par_b), .twisted_pair_param_a(tp_a), .pll_select(pll_select));

    mgmt_station sta (.clock(clock), .mdio_line(mdio_line), .mdc(mdc),
        .mdio_drv(sta_d), .mdio_drv_en(sta_en));

    always #25 clock = ~clock;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        sta.frame(phy_ext_pkg::OP_WRITE, PHYAD, a, d, rd);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        sta.frame(phy_ext_pkg::OP_READ, PHYAD, a, 16'h0000, rd);
        check($sformatf("register %h", a), exp, rd);
    endtask

    task automatic pulse(input logic [4:0] ev);
        @(posedge clock);
        #1 rx_events = phy_ext_pkg::rx_events_t'(ev);
        @(posedge clock);
        #1 rx_events = '0;
    endtask

    task automatic complete_run();
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // about 33 frames of some 1030 clocks each
    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        complete_run();
    end

    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        length_detect_ok_n = 1'b0;
        cable_len = 8'hA5;
        rx_events = '0;
        errors = 0;
        num_checks = 0;
        repeat (12) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        rd_chk(phy_ext_pkg::REG_LBR, 16'h0080);
        rd_chk(phy_ext_pkg::REG_TEN, 16'h0023);
        rd_chk(phy_ext_pkg::REG_RXCNT, 16'h0000);
        wr(phy_ext_pkg::REG_LBR, 16'hFFFF);
        rd_chk(phy_ext_pkg::REG_LBR, 16'hFB9F);
        check("lbr_ctrl", 16'hFB9F, lbr_ctrl);
        check("loop 11", 16'h0000, {14'h0000, phy_loopback, twisted_pair_loopback});
        length_detect_ok_n = 1'b1;
        rd_chk(phy_ext_pkg::REG_LBR, 16'hFF9F);
        for (int c = 0; c < 3; c++) begin
            wr(phy_ext_pkg::REG_LBR, {6'h00, c[1:0], 8'h80});
            check("loop flags", {14'h0000, c[1:0] == 2'b01, c[1:0] == 2'b10},
                  {14'h0000, phy_loopback, twisted_pair_loopback});
        end
        for (int k = 1; k < 5; k++) begin
            wr(phy_ext_pkg::REG_LBR, 16'h0080 | (16'h0001 << k));
            pulse(5'h01 << k);
            check("report on", 16'h0001, 16'(rx_error_report));
            pulse(k == 4 ? 5'h02 : 5'h01 << (k + 1));
            check("report off", 16'h0000, 16'(rx_error_report));
        end
        repeat (3) pulse(5'h01);
        rd_chk(phy_ext_pkg::REG_RXCNT, 16'h0003);
        wr(phy_ext_pkg::REG_RXCNT, 16'hFFFE);
        pulse(5'h01);
        rd_chk(phy_ext_pkg::REG_RXCNT, 16'hFFFF);
        check("receive_event_count", 16'hFFFF, receive_event_count);
        wr(phy_ext_pkg::REG_TEN, 16'hFFDC);
        rd_chk(phy_ext_pkg::REG_TEN, 16'h0000);
        check("ten_ctrl", 16'h0000, ten_ctrl);
        wr(phy_ext_pkg::REG_PAR_A, 16'h1234);
        rd_chk(phy_ext_pkg::REG_PAR_A, 16'h0000);
        wr(phy_ext_pkg::REG_LBR, 16'h0081);
        for (int i = 0; i < 4; i++) begin
            wr(5'h14 + 5'(i), vals[i]);
            rd_chk(5'h14 + 5'(i), i == 2 ? {8'hA5, vals[i][7:0]} : vals[i]);
        end
        check("param a", vals[0], par_a);
        check("param b", vals[1], par_b);
        check("pll", 16'h003C, {8'h00, pll_select});
        check("twisted", vals[3], tp_a);
        // the cable byte must follow its input, not a stored copy
        cable_len = 8'h5A;
        rd_chk(phy_ext_pkg::REG_CABLE_PLL, 16'h5A3C);
        rd_chk(5'h1F, 16'h0000);
        sta.frame(phy_ext_pkg::OP_READ, PHYAD ^ 5'h01, phy_ext_pkg::REG_LBR, 16'h0000, rd);
        check("foreign address", 16'hFFFF, rd);
        // a mid-run reset must bring registers 17..20 and pll_select back to their reset values
        nrst = 1'b0;
        repeat (3) @(posedge clock);
        #1 nrst = 1'b1;
        check("reset lbr_ctrl", 16'h0480, lbr_ctrl);
        check("reset ten_ctrl", 16'h0023, ten_ctrl);
        check("reset count", 16'h0000, receive_event_count);
        check("reset param a", 16'h0000, par_a);
        check("reset pll", 16'h0000, {8'h00, pll_select});
        repeat (10) @(posedge clock);
        #1;
        rd_chk(phy_ext_pkg::REG_LBR, 16'h0480);
        complete_run();
    end
endmodule // tb_phy_extended_config_regs
